// ### core/cdp_provisioning.sv
// Calendar and port descriptor provisioning for one link core
`timescale 1ns/1ns
// How it works
// - One select bit steers window writes
// - Select codes 20,10,08,04 pick memories
// - Calendar byte per slot holds port
// - Rx descriptor holds bank per port
// - Tx descriptor: 256 entries, three bytes
// - Tx entries four apart, fourth unused
// - Byte zero holds port identifier
// - Byte one: partition and burst value
// - Dual limit bit enables second limit
// - Port source bit picks tag source
// - Byte two: bank, dual, source bits
// - Static mode bits bypass PLL, skip training
// - Static mode forces status bit zero high
// - Static: bits six, seven low mean handshake
// - Override steps delay tap zero to six
// - Soft reset erases tx descriptors only
// - Calendar provisioned when length nonzero
module cdp_provisioning
   import cdp_pkg::*;
#(
   parameter int CAL_DEPTH = 1024,
   parameter int ENTRIES   = CDP_DESC_ENTRIES
) (
   input  wire logic                   clk_in,
   input  wire logic                   sys_rst_in,
   input  wire logic                   soft_rst_in,
   input  wire cdp_bus_req_type        bus_in,
   output logic      [7:0]             rdata_out,
   input  wire cdp_link_sts_type       link_sts_in,
   input  wire logic [10:0]            rx_cal_len_in,
   input  wire logic [10:0]            tx_cal_len_in,
   input  wire logic [9:0]             rx_slot_in,
   input  wire logic [9:0]             tx_slot_in,
   input  wire logic [7:0]             rx_port_in,
   input  wire logic                   delay_override_in,
   input  wire logic [2:0]             rx_delay_tap_in,
   output logic      [7:0]             rx_cal_port_out,
   output logic      [7:0]             rx_bank_out,
   output logic      [7:0]             tx_cal_port_out,
   output logic      [7:0]             tx_port_tag_out,
   output logic      [3:0]             burst_value_out,
   output logic      [2:0]             partition_out,
   output logic      [1:0]             bank_out,
   output logic                        first_limit_only_out,
   output logic                        second_limit_en_out,
   output logic                        static_mode_out,
   output logic                        training_en_out,
   output logic                        pll_bypass_out,
   output logic                        handshake_ok_out,
   output logic                        rx_cal_ready_out,
   output logic                        tx_cal_ready_out,
   output logic      [2:0]             rx_tap_out,
   output logic                        tap_override_out
);

   typedef struct packed {
      logic [7:0] mode;
      logic [7:0] mem_sel;
      logic [7:0] rdata;
      logic [2:0] tap;
      logic       tap_ovr;
   } cdp_state_type;

   cdp_state_type s_q, s_d;

   logic [7:0] rx_cal_mem  [CAL_DEPTH];
   logic [7:0] tx_cal_mem  [CAL_DEPTH];
   logic [7:0] rx_desc_mem [ENTRIES];

   logic              in_window;
   logic [11:0]       woff;
   logic              win_wr;
   logic              wr_rx_cal;
   logic              wr_tx_cal;
   logic              wr_rx_desc;
   logic              wr_tx_desc;
   logic              static_mode;
   logic [7:0]        sts_view;
   logic [7:0]        td_b0;
   logic [7:0]        td_b1;
   logic [7:0]        td_b2;
   logic              td_valid;
   cdp_tx_desc_type   td;

   // -----------------------------------------------------------------
   // Window decode
   // -----------------------------------------------------------------
   assign in_window = bus_in.addr >= CDP_WINDOW_BASE &&
                      bus_in.addr <= CDP_WINDOW_LAST;
   assign woff   = bus_in.addr[11:0];
   assign win_wr = bus_in.wr && in_window;
   // Exact code match: zero or multi-bit selects hit nothing
   assign wr_rx_cal  = win_wr && s_q.mem_sel == CDP_SEL_RX_CAL;
   assign wr_rx_desc = win_wr && s_q.mem_sel == CDP_SEL_RX_DESC;
   assign wr_tx_cal  = win_wr && s_q.mem_sel == CDP_SEL_TX_CAL;
   assign wr_tx_desc = win_wr && s_q.mem_sel == CDP_SEL_TX_DESC;

   // -----------------------------------------------------------------
   // Calendar and rx descriptor memories kept across core soft reset; tx descriptor store erased by it
   // -----------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (wr_rx_cal && woff < 12'(CAL_DEPTH)) begin
         rx_cal_mem[woff[9:0]] <= bus_in.wdata;
      end
      if (wr_tx_cal && woff < 12'(CAL_DEPTH)) begin
         tx_cal_mem[woff[9:0]] <= bus_in.wdata;
      end
      if (wr_rx_desc && woff < 12'(ENTRIES)) begin
         rx_desc_mem[woff[7:0]] <= bus_in.wdata;
      end
   end

   cdp_tx_desc_store #(
      .ENTRIES (ENTRIES)
   ) u_tx_descriptor_store (
      .clk_in       (clk_in),
      .sys_rst_in   (sys_rst_in),
      .soft_rst_in  (soft_rst_in),
      .wr_in        (wr_tx_desc && woff < 12'(ENTRIES * CDP_DESC_STRIDE)),
      .entry_in     (woff[9:2]),
      .byte_in      (woff[1:0]),
      .wdata_in     (bus_in.wdata),
      .rd_entry_in  (tx_cal_port_out),
      .rd_byte0_out (td_b0),
      .rd_byte1_out (td_b1),
      .rd_byte2_out (td_b2),
      .rd_valid_out (td_valid)
   );

   // -----------------------------------------------------------------
   // Descriptor field unpacking
   // -----------------------------------------------------------------
   always_comb begin
      td = '0;
      td.port_id                 = td_b0;
      td.burst_value_field       = td_b1[CDP_B1_BURST_LSB +: 4];
      td.buffer_partition_select = td_b1[CDP_B1_PART_LSB +: 3];
      td.buffer_bank_select      = td_b2[CDP_B2_BANK_LSB +: 2];
      td.port_src_desc           = td_b2[CDP_B2_PORTSRC_BIT];
      td.dual_limit_enable       = td_b2[CDP_B2_DUAL_BIT];
   end

   // -----------------------------------------------------------------
   // Lookup outputs toward the link logic
   // -----------------------------------------------------------------
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         rx_cal_port_out      <= 8'h00;
         tx_cal_port_out      <= 8'h00;
         rx_bank_out          <= 8'h00;
         tx_port_tag_out      <= 8'h00;
         burst_value_out      <= 4'h0;
         partition_out        <= 3'h0;
         bank_out             <= 2'h0;
         second_limit_en_out  <= 1'b0;
         first_limit_only_out <= 1'b1;
      end else begin
         rx_cal_port_out <= rx_cal_mem[rx_slot_in];
         tx_cal_port_out <= tx_cal_mem[tx_slot_in];
         rx_bank_out     <= rx_desc_mem[rx_port_in];
         tx_port_tag_out <= (td_valid && td.port_src_desc) ?
                            td.port_id : tx_cal_port_out;
         burst_value_out      <= td.burst_value_field;
         partition_out        <= td.buffer_partition_select;
         bank_out             <= td.buffer_bank_select;
         second_limit_en_out  <= td.dual_limit_enable;
         first_limit_only_out <= !td.dual_limit_enable;
      end
   end

   // -----------------------------------------------------------------
   // Mode and status interpretation
   // -----------------------------------------------------------------
   assign static_mode = s_q.mode[CDP_MODE_LOWSPD_BIT] ||
                        s_q.mode[CDP_MODE_QUARTER_BIT];
   assign static_mode_out = static_mode;
   assign training_en_out = !static_mode;
   assign pll_bypass_out  = static_mode;
   assign handshake_ok_out = static_mode &&
                             !link_sts_in.align_off &&
                             !link_sts_in.tx_lof;

   always_comb begin
      sts_view = {link_sts_in.tx_lof, link_sts_in.align_off,
                  link_sts_in.other[4:0], link_sts_in.rx_pll_lock_n};
      if (static_mode) begin
         sts_view[CDP_STS_PLL_BIT] = 1'b1;
      end
   end

   // Length owned elsewhere; nonzero means tables usable
   assign rx_cal_ready_out = rx_cal_len_in != 11'h000;
   assign tx_cal_ready_out = tx_cal_len_in != 11'h000;

   // -----------------------------------------------------------------
   // Delay tap override
   // -----------------------------------------------------------------
   assign rx_tap_out       = s_q.tap;
   assign tap_override_out = s_q.tap_ovr;
   assign rdata_out        = s_q.rdata;

   // -----------------------------------------------------------------
   // Register state
   // -----------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.tap_ovr = delay_override_in;
      // Taps above six are clamped, the eye has only seven steps
      if (!delay_override_in) begin
         s_d.tap = 3'h0;
      end else if (rx_delay_tap_in > CDP_TAP_MAX) begin
         s_d.tap = CDP_TAP_MAX;
      end else begin
         s_d.tap = rx_delay_tap_in;
      end
      if (bus_in.wr) begin
         case (bus_in.addr)
            CDP_MODE_SELECT_ADDR: s_d.mode    = bus_in.wdata;
            CDP_MEM_SELECT_ADDR:  s_d.mem_sel = bus_in.wdata;
            default: ;
         endcase
      end
      if (bus_in.rd) begin
         case (bus_in.addr)
            CDP_ALIGN_STATUS_ADDR: s_d.rdata = sts_view;
            CDP_MODE_SELECT_ADDR:  s_d.rdata = s_q.mode;
            CDP_MEM_SELECT_ADDR:   s_d.rdata = s_q.mem_sel;
            default:               s_d.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         s_q <= '{mode: CDP_REG_RESET, mem_sel: CDP_REG_RESET,
                  rdata: 8'h00, tap: 3'h0, tap_ovr: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

endmodule

// ### include/cdp_pkg.sv
// Shared constants and types for calendar and descriptor provisioning
package cdp_pkg;

   // -----------------------------------------------------------------
   // Register map
   // -----------------------------------------------------------------
   localparam logic [19:0] CDP_ALIGN_STATUS_ADDR = 20'h30910;
   localparam logic [19:0] CDP_MODE_SELECT_ADDR  = 20'h30915;
   localparam logic [19:0] CDP_MEM_SELECT_ADDR   = 20'h30917;
   localparam logic [19:0] CDP_WINDOW_BASE       = 20'h31000;
   localparam logic [19:0] CDP_WINDOW_LAST       = 20'h31fff;

   // Memory select codes
   localparam logic [7:0] CDP_SEL_RX_CAL  = 8'h20;
   localparam logic [7:0] CDP_SEL_RX_DESC = 8'h10;
   localparam logic [7:0] CDP_SEL_TX_CAL  = 8'h08;
   localparam logic [7:0] CDP_SEL_TX_DESC = 8'h04;

   // Mode register bits
   localparam int CDP_MODE_QUARTER_BIT = 0;
   localparam int CDP_MODE_LOWSPD_BIT  = 2;

   // Status register bits
   localparam int CDP_STS_PLL_BIT   = 0;
   localparam int CDP_STS_ALIGN_BIT = 6;
   localparam int CDP_STS_LOF_BIT   = 7;

   // Descriptor layout
   localparam int CDP_DESC_ENTRIES   = 256;
   localparam int CDP_DESC_STRIDE    = 4;
   localparam int CDP_B1_BURST_LSB   = 0;
   localparam int CDP_B1_PART_LSB    = 4;
   localparam int CDP_B2_BANK_LSB    = 0;
   localparam int CDP_B2_PORTSRC_BIT = 2;
   localparam int CDP_B2_DUAL_BIT    = 3;

   // Delay tap limit
   localparam logic [2:0] CDP_TAP_MAX = 3'h6;

   // Reset values
   localparam logic [7:0] CDP_REG_RESET = 8'h00;

   // -----------------------------------------------------------------
   // Types
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] port_id;
      logic [2:0] buffer_partition_select;
      logic [3:0] burst_value_field;
      logic       dual_limit_enable;
      logic       port_src_desc;
      logic [1:0] buffer_bank_select;
   } cdp_tx_desc_type;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [19:0] addr;
      logic [7:0]  wdata;
   } cdp_bus_req_type;

   typedef struct packed {
      logic       rx_pll_lock_n;
      logic       align_off;
      logic       tx_lof;
      logic [4:0] other;
   } cdp_link_sts_type;

endpackage

// ### core/cdp_tx_desc_store.sv
// Transmit descriptor store, erased by core soft reset
`timescale 1ns/1ns
module cdp_tx_desc_store
   import cdp_pkg::*;
#(
   parameter int ENTRIES = CDP_DESC_ENTRIES
) (
   input  wire logic                       clk_in,
   input  wire logic                       sys_rst_in,
   input  wire logic                       soft_rst_in,
   input  wire logic                       wr_in,
   input  wire logic [$clog2(ENTRIES)-1:0] entry_in,
   input  wire logic [1:0]                 byte_in,
   input  wire logic [7:0]                 wdata_in,
   input  wire logic [$clog2(ENTRIES)-1:0] rd_entry_in,
   output logic      [7:0]                 rd_byte0_out,
   output logic      [7:0]                 rd_byte1_out,
   output logic      [7:0]                 rd_byte2_out,
   output logic                            rd_valid_out
);

   logic [7:0] mem_b0 [ENTRIES];
   logic [7:0] mem_b1 [ENTRIES];
   logic [7:0] mem_b2 [ENTRIES];
   logic [ENTRIES-1:0] valid_q;

   // -----------------------------------------------------------------
   // Storage
   // -----------------------------------------------------------------
   // Valid bits model the erase; payload RAM needs no reset
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         valid_q <= '0;
      end else if (soft_rst_in) begin
         valid_q <= '0;
      end else if (wr_in && byte_in != 2'd3) begin
         valid_q[entry_in] <= 1'b1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (wr_in && !soft_rst_in) begin
         case (byte_in)
            2'd0: mem_b0[entry_in] <= wdata_in;
            2'd1: mem_b1[entry_in] <= wdata_in;
            2'd2: mem_b2[entry_in] <= wdata_in;
            default: ;
         endcase
      end
   end

   always_comb begin
      rd_valid_out = valid_q[rd_entry_in];
      rd_byte0_out = rd_valid_out ? mem_b0[rd_entry_in] : 8'h00;
      rd_byte1_out = rd_valid_out ? mem_b1[rd_entry_in] : 8'h00;
      rd_byte2_out = rd_valid_out ? mem_b2[rd_entry_in] : 8'h00;
   end

endmodule

// ### tb/cdp_provisioning_asserts.sv
// Port-level assertions for the provisioning block
`timescale 1ns/1ns
module cdp_prov_asserts
   import cdp_pkg::*;
(
   input wire logic             clk_in,
   input wire logic             sys_rst_in,
   input wire cdp_bus_req_type  bus_in,
   input wire logic [7:0]       rdata_out,
   input wire cdp_link_sts_type link_sts_in,
   input wire logic [10:0]      rx_cal_len_in,
   input wire logic [10:0]      tx_cal_len_in,
   input wire logic             delay_override_in,
   input wire logic [2:0]       rx_delay_tap_in,
   input wire logic             first_limit_only_out,
   input wire logic             second_limit_en_out,
   input wire logic             static_mode_out,
   input wire logic             training_en_out,
   input wire logic             pll_bypass_out,
   input wire logic             handshake_ok_out,
   input wire logic             rx_cal_ready_out,
   input wire logic             tx_cal_ready_out,
   input wire logic [2:0]       rx_tap_out,
   input wire logic             tap_override_out
);
   // Shadow of the mode register, rebuilt from bus writes
   logic [7:0] mode_q;
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in)
         mode_q <= 8'h00;
      else if (bus_in.wr && bus_in.addr == CDP_MODE_SELECT_ADDR)
         mode_q <= bus_in.wdata;
   end
   default clocking @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   rx_ready_a: assert property (rx_cal_ready_out == |rx_cal_len_in)
      else $error("rx calendar ready wrong");
   tx_ready_a: assert property (tx_cal_ready_out == |tx_cal_len_in)
      else $error("tx calendar ready wrong");
   static_mode_a: assert property (static_mode_out ==
      (mode_q[CDP_MODE_QUARTER_BIT] | mode_q[CDP_MODE_LOWSPD_BIT]))
      else $error("static mode decode wrong");
   train_pll_a: assert property (training_en_out != static_mode_out
      && pll_bypass_out == static_mode_out) else $error("bypass wrong");
   handshake_a: assert property (handshake_ok_out == (static_mode_out
      && !link_sts_in.align_off && !link_sts_in.tx_lof))
      else $error("handshake flag wrong");
   limit_pair_a: assert property (first_limit_only_out
      != second_limit_en_out) else $error("burst limit flags clash");
   tap_step_a: assert property (delay_override_in |=> tap_override_out
      && rx_tap_out == (($past(rx_delay_tap_in) > CDP_TAP_MAX) ?
      CDP_TAP_MAX : $past(rx_delay_tap_in))) else $error("tap wrong");
   tap_off_a: assert property (!delay_override_in |=>
      rx_tap_out == 3'h0 && !tap_override_out) else $error("tap not idle");
   sts_read_a: assert property (bus_in.rd &&
      bus_in.addr == CDP_ALIGN_STATUS_ADDR |=>
      rdata_out[7] == $past(link_sts_in.tx_lof) &&
      rdata_out[6] == $past(link_sts_in.align_off) &&
      (rdata_out[0] || !$past(static_mode_out)))
      else $error("status read wrong");
endmodule
bind cdp_provisioning cdp_prov_asserts i_chk (.clk_in, .sys_rst_in, .bus_in,
   .rdata_out, .link_sts_in, .rx_cal_len_in, .tx_cal_len_in,
   .delay_override_in, .rx_delay_tap_in, .first_limit_only_out,
   .second_limit_en_out, .static_mode_out, .training_en_out,
   .pll_bypass_out, .handshake_ok_out, .rx_cal_ready_out,
   .tx_cal_ready_out, .rx_tap_out, .tap_override_out);

// ### tb/cdp_host_model.sv
// Host processor and fabric model driving the register bus
`timescale 1ns/1ns
module cdp_host_model
   import cdp_pkg::*;
(
   input  wire logic       clk_in,
   input  wire logic [7:0] rdata_in,
   output cdp_bus_req_type bus_out,
   output logic [10:0]     rx_cal_len_out,
   output logic [10:0]     tx_cal_len_out
);
   initial begin
      bus_out = '{wr: 1'b0, rd: 1'b0, addr: 20'h0, wdata: 8'h0};
      rx_cal_len_out = 11'h0;
      tx_cal_len_out = 11'h0;
   end
   // Idle bus shows inverted values so stale data cannot pass
   task automatic cycle(input logic w, input logic [19:0] a,
                        input logic [7:0] d);
      @(posedge clk_in);
      #1;
      bus_out = '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge clk_in);
      #1;
      bus_out = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask
   task automatic wr(input logic [19:0] a, input logic [7:0] d);
      cycle(1'b1, a, d);
   endtask
   task automatic rd(input logic [19:0] a, output logic [7:0] d);
      cycle(1'b0, a, 8'h00);
      @(posedge clk_in);
      #1;
      d = rdata_in;
   endtask
   // Select first, table next, calendar length last
   task automatic prog(input logic [7:0] sel, input logic [19:0] off,
                       input logic [7:0] d[$]);
      wr(CDP_MEM_SELECT_ADDR, sel);
      foreach (d[i])
         wr(CDP_WINDOW_BASE + off + 20'(i), d[i]);
      if (sel == CDP_SEL_RX_CAL)
         rx_cal_len_out = 11'(d.size());
      if (sel == CDP_SEL_TX_CAL)
         tx_cal_len_out = 11'(d.size());
   endtask
endmodule

// ### tb/testbench.sv
// Self-checking bench for calendar and descriptor provisioning
`timescale 1ns/1ns
module testbench
   import cdp_pkg::*;
;
   logic             clk_in, sys_rst_in, soft_rst_in;
   cdp_bus_req_type  bus_in;
   cdp_link_sts_type link_sts_in;
   logic [10:0]      rx_cal_len_in, tx_cal_len_in;
   logic [9:0]       rx_slot_in, tx_slot_in;
   logic [7:0]       rx_port_in, rdata_out, rx_cal_port_out, rx_bank_out;
   logic [7:0]       tx_cal_port_out, tx_port_tag_out, d;
   logic [3:0]       burst_value_out;
   logic [2:0]       rx_delay_tap_in, partition_out, rx_tap_out;
   logic [1:0]       bank_out;
   logic             delay_override_in, first_limit_only_out;
   logic             second_limit_en_out, static_mode_out, training_en_out;
   logic             pll_bypass_out, handshake_ok_out, rx_cal_ready_out;
   logic             tx_cal_ready_out, tap_override_out, st;
   int               fail_count, n_checks, cycles;
   cdp_provisioning i_dut (.clk_in, .sys_rst_in, .soft_rst_in, .bus_in,
      .rdata_out, .link_sts_in, .rx_cal_len_in, .tx_cal_len_in, .rx_slot_in,
      .tx_slot_in, .rx_port_in, .delay_override_in, .rx_delay_tap_in,
      .rx_cal_port_out, .rx_bank_out, .tx_cal_port_out, .tx_port_tag_out,
      .burst_value_out, .partition_out, .bank_out, .first_limit_only_out,
      .second_limit_en_out, .static_mode_out, .training_en_out,
      .pll_bypass_out, .handshake_ok_out, .rx_cal_ready_out,
      .tx_cal_ready_out, .rx_tap_out, .tap_override_out);
   cdp_host_model i_host (.clk_in, .rdata_in(rdata_out), .bus_out(bus_in),
      .rx_cal_len_out(rx_cal_len_in), .tx_cal_len_out(tx_cal_len_in));
   initial begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 8000) begin
         fail_count++;
         close_out();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                      input string what);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   // Kept pass: no reprogramming, tables must survive soft reset
   task automatic t_calendars(input logic kept);
      i_host.rd(20'h20000, d);
      chk(d, 8'h00, "unmapped read");
      chk(rx_cal_ready_out, kept, "rx ready early");
      chk(tx_cal_ready_out, kept, "tx ready early");
      if (!kept) begin
         i_host.prog(CDP_SEL_RX_CAL, 20'h0, '{8'h03, 8'h02, 8'h01, 8'h00});
         i_host.prog(CDP_SEL_TX_CAL, 20'h0, '{0, 1, 2, 3, 8'hff});
         i_host.rd(CDP_MEM_SELECT_ADDR, d);
         chk(d, CDP_SEL_TX_CAL, "select readback");
         i_host.prog(CDP_SEL_RX_DESC, 20'h0, '{8'h00, 8'h08, 8'h10, 8'h18});
      end
      for (int i = 0; i < 4; i++) begin
         rx_slot_in = 10'(i);
         rx_port_in = 8'(i);
         tick(3);
         chk(rx_cal_port_out, 8'(3 - i), "rx calendar slot");
         chk(rx_bank_out, 8'(i * 8), "rx bank");
      end
      chk(rx_cal_ready_out, 1'b1, "rx ready");
      chk(tx_cal_ready_out, 1'b1, "tx ready");
   endtask
   task automatic t_tx_desc(input logic erased);
      logic [7:0] pid[5] = '{8'h40, 8'h41, 8'h42, 8'h43, 8'h77};
      logic [7:0] b1[5] = '{8'h0f, 8'h1e, 8'h2d, 8'h3c, 8'h5a};
      logic [7:0] b2[5] = '{8'h0c, 8'h05, 8'h0a, 8'h01, 8'h0d};
      logic [7:0] cp;
      for (int i = 0; i < 5; i++) begin
         tx_slot_in = 10'(i);
         tick(4);
         cp = (i < 4) ? 8'(i) : 8'hff;
         if (erased) begin
            pid[i] = 8'h00;
            b1[i] = 8'h00;
            b2[i] = 8'h00;
         end
         chk(tx_cal_port_out, cp, "tx calendar slot");
         chk(tx_port_tag_out, b2[i][2] ? pid[i] : cp, "tag");
         chk(burst_value_out, b1[i][3:0], "burst");
         chk(partition_out, b1[i][6:4], "partition");
         chk(bank_out, b2[i][1:0], "bank");
         chk(second_limit_en_out, b2[i][3], "dual limit");
         chk(first_limit_only_out, !b2[i][3], "single limit");
      end
   endtask
   initial begin
      sys_rst_in = 1'b1;
      soft_rst_in = 1'b0;
      link_sts_in = '0;
      rx_slot_in = 10'h0;
      tx_slot_in = 10'h0;
      rx_port_in = 8'h00;
      delay_override_in = 1'b0;
      rx_delay_tap_in = 3'h0;
      repeat (6) @(posedge clk_in);
      #1;
      sys_rst_in = 1'b0;
      t_calendars(1'b0);
      i_host.prog(CDP_SEL_TX_DESC, 20'h0, '{8'h40, 8'h0f, 8'h0c, 8'hee,
         8'h41, 8'h1e, 8'h05, 8'hee, 8'h42, 8'h2d, 8'h0a, 8'hee,
         8'h43, 8'h3c, 8'h01, 8'hee});
      i_host.prog(CDP_SEL_TX_DESC, 20'h3fc, '{8'h77, 8'h5a, 8'h0d});
      i_host.prog(8'h00, 20'h0, '{8'haa});
      i_host.prog(8'h30, 20'h0, '{8'hbb});
      t_tx_desc(1'b0);
      soft_rst_in = 1'b1;
      tick(260);
      soft_rst_in = 1'b0;
      t_tx_desc(1'b1);
      t_calendars(1'b1);
      for (int m = 0; m < 8; m++) begin
         st = m[1] | m[2];
         i_host.wr(CDP_MODE_SELECT_ADDR, {5'h0, m[2], 1'b0, m[1]});
         link_sts_in = '{1'b0, m[0], !m[0], 5'h0};
         i_host.rd(CDP_ALIGN_STATUS_ADDR, d);
         chk(training_en_out, !st, "training");
         chk(pll_bypass_out, st, "pll bypass");
         chk(d, {!m[0], m[0], 5'h0, st}, "status");
         chk(handshake_ok_out, 1'b0, "handshake busy");
         link_sts_in = '0;
         tick(1);
         chk(handshake_ok_out, st, "handshake");
      end
      for (int t = 0; t < 9; t++) begin
         delay_override_in = (t < 8);
         rx_delay_tap_in = 3'(t);
         tick(2);
         chk(rx_tap_out, (t > 7) ? 3'h0 : (t > 6) ? 3'h6 : t, "tap");
         chk(tap_override_out, t < 8, "tap override");
      end
      close_out();
   end
endmodule
